// *** rtl/flic_top.v ***
// Flash in-application programming controller, register side and sequencer
// Contract
// - Erase and write by page, read by word
// - Page and buffer both 2**PAGE_W words, indexed by PAGE_W bits
// - Enable flag set on unlock; gates loads
// - Write start begins write, cleared when done
// - Read needs enable; start cleared when done
// - Buffer page chosen by upper address bits
// - Buffer clear bit self-clears when finished
// - Low byte stores; high byte loads word
// - Address increments after each word load
// - Address holds at last word of page
// - Buffer cleared automatically after write
// - Registers split over sector 0 and 1
// - Low address byte read/write, resets zero
// - Mode codes write, erase, read, enable
// - Trigger runs 1ms window, self-clears
// - Writing one to flag ignored; zero disables
// - Core held while a start bit set
`include "flic_defines.vh"

module flic_top #(
  parameter        ADDR_W        = 15,
  parameter        PAGE_W        = 6,
  parameter        UNLOCK_CYCLES = `FLIC_UNLOCK_US * `FLIC_CLK_MHZ,
  parameter [15:0] UNLOCK_PAT1   = 16'h1234,
  parameter [15:0] UNLOCK_PAT2   = 16'h5678,
  parameter [15:0] UNLOCK_PAT3   = 16'h9ABC
) (
  // Clock and reset
  input  wire              clock,
  input  wire              arst_n,
  // Special-function register access
  input  wire              sfrSector,
  input  wire [2:0]        sfrIndex,
  input  wire              sfrWrEn,
  input  wire              sfrRdEn,
  input  wire [7:0]        sfrWrData,
  output reg  [7:0]        sfrRdData,
  // Core stall
  output reg               cpuHold,
  // Flash array
  output reg               flashEraseStart,
  output reg               flashProgStart,
  output reg               flashReadStart,
  output reg  [ADDR_W-1:0] flashAddr,
  output reg               progWordValid,
  output reg  [PAGE_W-1:0] progWordIndex,
  output reg  [15:0]       progWordData,
  input  wire              flashDone,
  input  wire [15:0]       flashReadData
);

  localparam HI_W  = ADDR_W - 8;
  localparam TMR_W = 17;

  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_STREAM = 3'h1;
  localparam [2:0] S_COMMIT = 3'h2;
  localparam [2:0] S_PWAIT  = 3'h3;
  localparam [2:0] S_CLEAR  = 3'h4;
  localparam [2:0] S_ERASE  = 3'h5;
  localparam [2:0] S_READ   = 3'h6;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire       wr0       = sfrWrEn & ~sfrSector;
  wire       wr1       = sfrWrEn & sfrSector;
  wire       fcrWrite  = wr1 && (sfrIndex == `FLIC_S1_CONTROL);
  wire       frcrWrite = wr1 && (sfrIndex == `FLIC_S1_BUF_CTRL);
  wire       farlWrite = wr0 && (sfrIndex == `FLIC_S0_ADDR_LOW);
  wire       farhWrite = wr1 && (sfrIndex == `FLIC_S1_ADDR_HIGH);
  wire [3:0] wrLow;
  wire [3:0] wrHigh;
  wire [3:0] patHit;
  wire [31:0] lowV;
  wire [31:0] highV;
  wire [63:0] patFlat = {UNLOCK_PAT3, UNLOCK_PAT2, UNLOCK_PAT1, 16'h0000};

  reg [7:0]      addrLow;
  reg [HI_W-1:0] addrHigh;
  reg            ewEnabled;
  reg [2:0]      opMode;
  reg            trigBusy;
  reg            writeStart;
  reg            readEnable;
  reg            readStart;
  reg            clearReq;
  reg [2:0]      unlockSeen;
  reg [2:0]      state;
  reg [PAGE_W-1:0] streamIdx;

  wire              timerExpired;
  wire              bufBusy;
  wire              bufDone;
  wire [15:0]       bufRdData;
  wire [ADDR_W-1:0] fullAddr = {addrHigh, addrLow};
  wire [ADDR_W-1:0] pageBase = {fullAddr[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};

  // ----------------------------------------
  // Data register pairs
  // ----------------------------------------
  wire readLoad = (state == S_READ) && flashDone;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : pair
      localparam LOW_IDX  = `FLIC_S0_DATA0_LOW + g;
      localparam HIGH_IDX = `FLIC_S1_DATA0_HIGH + g;
      reg [7:0] lo;
      reg [7:0] hi;
      assign wrLow[g]      = wr0 && (sfrIndex == LOW_IDX[2:0]);
      assign wrHigh[g]     = wr1 && (sfrIndex == HIGH_IDX[2:0]);
      assign lowV[g*8+:8]  = lo;
      assign highV[g*8+:8] = hi;
      assign patHit[g]     = wrHigh[g] && ({sfrWrData, lo} == patFlat[g*16+:16]);
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          lo <= `FLIC_REG_RESET;
          hi <= `FLIC_REG_RESET;
        end else if ((g == 0) && readLoad) begin
          {hi, lo} <= flashReadData;
        end else begin
          if (wrLow[g]) begin
            lo <= sfrWrData;
          end
          if (wrHigh[g]) begin
            hi <= sfrWrData;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Word load and address advance
  // ----------------------------------------
  wire loadWord = wrHigh[0] && ewEnabled && !bufBusy;
  wire atEnd    = &fullAddr[PAGE_W-1:0];
  wire [ADDR_W-1:0] incAddr = atEnd ? fullAddr : fullAddr + 1'b1;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addrLow  <= `FLIC_REG_RESET;
      addrHigh <= {HI_W{1'b0}};
    end else if (loadWord) begin
      {addrHigh, addrLow} <= incAddr;
    end else begin
      if (farlWrite) begin
        addrLow <= sfrWrData;
      end
      if (farhWrite) begin
        addrHigh <= sfrWrData[HI_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Unlock procedure
  // ----------------------------------------
  wire trigSet   = fcrWrite && sfrWrData[`FLIC_CTL_TRIGGER];
  wire trigClr   = fcrWrite && !sfrWrData[`FLIC_CTL_TRIGGER];
  wire unlockHit = trigBusy && (opMode == `FLIC_MODE_ENABLE) && (&unlockSeen);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      unlockSeen <= 3'h0;
    end else if (trigSet) begin
      unlockSeen <= 3'h0;
    end else if (trigBusy && (opMode == `FLIC_MODE_ENABLE)) begin
      unlockSeen <= unlockSeen | patHit[3:1];
    end
  end

  flic_timeout #(
    .CYCLES (UNLOCK_CYCLES),
    .CNT_W  (TMR_W)
  ) u_timer (
    .clock   (clock),
    .arst_n  (arst_n),
    .start   (trigSet),
    .cancel  (trigClr),
    .expired (timerExpired)
  );

  // ----------------------------------------
  // Sequencer decisions
  // ----------------------------------------
  wire writeOk = ewEnabled && (opMode == `FLIC_MODE_WRITE);
  wire eraseOk = ewEnabled && (opMode == `FLIC_MODE_ERASE);
  wire readOk  = readEnable && (opMode == `FLIC_MODE_READ);

  wire writeDone = ((state == S_CLEAR) && bufDone) ||
                   ((state == S_ERASE) && flashDone) ||
                   ((state == S_IDLE) && writeStart && !writeOk && !eraseOk);
  wire readDone  = readLoad ||
                   ((state == S_IDLE) && !writeStart && readStart && !readOk);
  wire autoClear = (state == S_PWAIT) && flashDone;
  wire clwbSet   = frcrWrite && sfrWrData[`FLIC_BUF_CLEAR];

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  reg       next_ewEnabled;
  reg [2:0] next_opMode;
  reg       next_trigBusy;
  reg       next_writeStart;
  reg       next_readEnable;
  reg       next_readStart;
  reg       next_clearReq;

  always @* begin
    next_ewEnabled  = ewEnabled;
    next_opMode     = opMode;
    next_trigBusy   = trigBusy;
    next_writeStart = writeStart;
    next_readEnable = readEnable;
    next_readStart  = readStart;
    next_clearReq   = clearReq;
    if (timerExpired) begin
      next_trigBusy = 1'b0;
    end
    if (writeDone) begin
      next_writeStart = 1'b0;
    end
    if (readDone) begin
      next_readStart = 1'b0;
    end
    if (bufDone) begin
      next_clearReq = 1'b0;
    end
    if (fcrWrite) begin
      next_opMode     = sfrWrData[`FLIC_CTL_MODE_HI:`FLIC_CTL_MODE_LO];
      next_trigBusy   = sfrWrData[`FLIC_CTL_TRIGGER];
      next_readEnable = sfrWrData[`FLIC_CTL_RDEN];
      if (!sfrWrData[`FLIC_CTL_EW_EN]) begin
        next_ewEnabled = 1'b0;
      end
      if (sfrWrData[`FLIC_CTL_WSTART]) begin
        next_writeStart = 1'b1;
      end
      if (sfrWrData[`FLIC_CTL_RSTART]) begin
        next_readStart = 1'b1;
      end
    end
    if (unlockHit) begin
      next_ewEnabled = 1'b1;
    end
    if (clwbSet) begin
      next_clearReq = 1'b1;
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ewEnabled  <= 1'b0;
      opMode     <= 3'h0;
      trigBusy   <= 1'b0;
      writeStart <= 1'b0;
      readEnable <= 1'b0;
      readStart  <= 1'b0;
      clearReq   <= 1'b0;
      cpuHold    <= 1'b0;
    end else begin
      ewEnabled  <= next_ewEnabled;
      opMode     <= next_opMode;
      trigBusy   <= next_trigBusy;
      writeStart <= next_writeStart;
      readEnable <= next_readEnable;
      readStart  <= next_readStart;
      clearReq   <= next_clearReq;
      cpuHold    <= next_writeStart | next_readStart;
    end
  end

  // ----------------------------------------
  // Write buffer
  // ----------------------------------------
  flic_wbuf #(
    .DATA_W (16),
    .IDX_W  (PAGE_W)
  ) u_wbuf (
    .clock      (clock),
    .arst_n     (arst_n),
    .wrEn       (loadWord),
    .wrIdx      (fullAddr[PAGE_W-1:0]),
    .wrData     ({sfrWrData, lowV[7:0]}),
    .rdIdx      (streamIdx),
    .rdData     (bufRdData),
    .clearStart (clwbSet | autoClear),
    .clearBusy  (bufBusy),
    .clearDone  (bufDone)
  );

  // ----------------------------------------
  // Flash sequencer
  // ----------------------------------------
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state           <= S_IDLE;
      streamIdx       <= {PAGE_W{1'b0}};
      flashEraseStart <= 1'b0;
      flashProgStart  <= 1'b0;
      flashReadStart  <= 1'b0;
      flashAddr       <= {ADDR_W{1'b0}};
      progWordValid   <= 1'b0;
      progWordIndex   <= {PAGE_W{1'b0}};
      progWordData    <= 16'h0000;
    end else begin
      flashEraseStart <= 1'b0;
      flashProgStart  <= 1'b0;
      flashReadStart  <= 1'b0;
      progWordValid   <= 1'b0;
      case (state)
        S_IDLE: begin
          if (writeStart && writeOk) begin
            flashAddr <= pageBase;
            streamIdx <= {PAGE_W{1'b0}};
            state     <= S_STREAM;
          end else if (writeStart && eraseOk) begin
            flashAddr       <= pageBase;
            flashEraseStart <= 1'b1;
            state           <= S_ERASE;
          end else if (!writeStart && readStart && readOk) begin
            flashAddr      <= fullAddr;
            flashReadStart <= 1'b1;
            state          <= S_READ;
          end
        end
        S_STREAM: begin
          progWordValid <= 1'b1;
          progWordIndex <= streamIdx;
          progWordData  <= bufRdData;
          streamIdx     <= streamIdx + 1'b1;
          if (&streamIdx) begin
            state <= S_COMMIT;
          end
        end
        S_COMMIT: begin
          flashProgStart <= 1'b1;
          state          <= S_PWAIT;
        end
        S_PWAIT: begin
          if (flashDone) begin
            state <= S_CLEAR;
          end
        end
        S_CLEAR: begin
          if (bufDone) begin
            state <= S_IDLE;
          end
        end
        S_ERASE: begin
          if (flashDone) begin
            state <= S_IDLE;
          end
        end
        S_READ: begin
          if (flashDone) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register read-back
  // ----------------------------------------
  reg [7:0] readMux;

  always @* begin
    readMux = 8'h00;
    if (!sfrSector) begin
      case (sfrIndex)
        `FLIC_S0_ADDR_LOW: readMux = addrLow;
        3'h1:              readMux = lowV[7:0];
        3'h2:              readMux = lowV[15:8];
        3'h3:              readMux = lowV[23:16];
        3'h4:              readMux = lowV[31:24];
        default:           readMux = 8'h00;
      endcase
    end else begin
      case (sfrIndex)
        `FLIC_S1_CONTROL:   readMux = {ewEnabled, opMode, trigBusy, writeStart, readEnable, readStart};
        `FLIC_S1_BUF_CTRL:  readMux = {7'h00, clearReq};
        `FLIC_S1_ADDR_HIGH: readMux = {{(16-ADDR_W){1'b0}}, addrHigh};
        3'h3:               readMux = highV[7:0];
        3'h4:               readMux = highV[15:8];
        3'h5:               readMux = highV[23:16];
        3'h6:               readMux = highV[31:24];
        default:            readMux = 8'h00;
      endcase
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sfrRdData <= 8'h00;
    end else if (sfrRdEn) begin
      sfrRdData <= readMux;
    end
  end

endmodule // flic_top

// *** common/flic_defines.vh ***
// Constants for the flash programming controller
`ifndef FLIC_DEFINES_VH
`define FLIC_DEFINES_VH

// ----------------------------------------
// Register index, sector 0
// ----------------------------------------
`define FLIC_S0_ADDR_LOW   3'h0
`define FLIC_S0_DATA0_LOW  3'h1

// ----------------------------------------
// Register index, sector 1
// ----------------------------------------
`define FLIC_S1_CONTROL    3'h0
`define FLIC_S1_BUF_CTRL   3'h1
`define FLIC_S1_ADDR_HIGH  3'h2
`define FLIC_S1_DATA0_HIGH 3'h3

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define FLIC_CTL_EW_EN     7
`define FLIC_CTL_MODE_HI   6
`define FLIC_CTL_MODE_LO   4
`define FLIC_CTL_TRIGGER   3
`define FLIC_CTL_WSTART    2
`define FLIC_CTL_RDEN      1
`define FLIC_CTL_RSTART    0
`define FLIC_BUF_CLEAR     0

// ----------------------------------------
// Operation modes
// ----------------------------------------
`define FLIC_MODE_WRITE    3'h0
`define FLIC_MODE_ERASE    3'h1
`define FLIC_MODE_READ     3'h3
`define FLIC_MODE_ENABLE   3'h6

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define FLIC_REG_RESET     8'h00
`define FLIC_BUF_CLEAR_VAL 16'h0000
`define FLIC_CLK_MHZ       50
`define FLIC_UNLOCK_US     1000

`endif

// *** rtl/flic_timeout.v ***
// One-shot timeout counter for the unlock window
module flic_timeout #(
  parameter CYCLES = 50000,
  parameter CNT_W  = 17
) (
  // Clock and reset
  input  wire             clock,
  input  wire             arst_n,
  // Control
  input  wire             start,
  input  wire             cancel,
  // Status
  output reg              expired
);

  localparam LOAD = CYCLES - 1;

  reg [CNT_W-1:0] count;
  reg             running;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count   <= {CNT_W{1'b0}};
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        count   <= LOAD[CNT_W-1:0];
        running <= 1'b1;
      end else if (cancel) begin
        running <= 1'b0;
      end else if (running) begin
        if (count == {CNT_W{1'b0}}) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule // flic_timeout

// *** rtl/flic_wbuf.v ***
// Page write buffer with self-timed clear sweep
`include "flic_defines.vh"

module flic_wbuf #(
  parameter DATA_W = 16,
  parameter IDX_W  = 6
) (
  // Clock and reset
  input  wire              clock,
  input  wire              arst_n,
  // Word load
  input  wire              wrEn,
  input  wire [IDX_W-1:0]  wrIdx,
  input  wire [DATA_W-1:0] wrData,
  // Word fetch
  input  wire [IDX_W-1:0]  rdIdx,
  output wire [DATA_W-1:0] rdData,
  // Clear
  input  wire              clearStart,
  output reg               clearBusy,
  output reg               clearDone
);

  reg [DATA_W-1:0] mem [0:(1<<IDX_W)-1];
  reg [IDX_W-1:0]  sweep;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clearBusy <= 1'b0;
      clearDone <= 1'b0;
      sweep     <= {IDX_W{1'b0}};
    end else begin
      clearDone <= 1'b0;
      if (clearBusy) begin
        sweep <= sweep + 1'b1;
        if (&sweep) begin
          clearBusy <= 1'b0;
          clearDone <= 1'b1;
        end
      end else if (clearStart) begin
        clearBusy <= 1'b1;
        sweep     <= {IDX_W{1'b0}};
      end
    end
  end

  // Loads are dropped while a clear sweeps the page
  always @(posedge clock) begin
    if (clearBusy) begin
      mem[sweep] <= `FLIC_BUF_CLEAR_VAL;
    end else if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  assign rdData = mem[rdIdx];

endmodule // flic_wbuf

// *** tb/flic_top_monitor.sv ***
// Port checker for the flash programming controller
module flic_top_monitor #(
  parameter ADDR_W = 15,
  parameter PAGE_W = 6
) (
  // Clock and reset
  input wire              clock,
  input wire              arst_n,
  // Register access
  input wire              sfrRdEn,
  input wire [7:0]        sfrRdData,
  // Sequencer
  input wire              cpuHold,
  input wire              flashEraseStart,
  input wire              flashProgStart,
  input wire              flashReadStart,
  input wire [ADDR_W-1:0] flashAddr,
  input wire              progWordValid,
  input wire [PAGE_W-1:0] progWordIndex,
  input wire              flashDone
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [PAGE_W:0] wordCnt;
  logic            readPend;
  logic            erasePend;
  logic            progPend;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wordCnt   <= '0;
      readPend  <= 1'b0;
      erasePend <= 1'b0;
      progPend  <= 1'b0;
    end else begin
      wordCnt   <= flashProgStart ? '0 : wordCnt + progWordValid;
      readPend  <= flashReadStart | (readPend & ~flashDone);
      erasePend <= flashEraseStart | (erasePend & ~flashDone);
      progPend  <= flashProgStart | (progPend & ~flashDone);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_erase_base; flashEraseStart |-> flashAddr[PAGE_W-1:0] == '0; endproperty
  a_erase_base: assert property (p_erase_base) else $error("erase address not page base");
  property p_prog_base; flashProgStart |-> flashAddr[PAGE_W-1:0] == '0; endproperty
  a_prog_base: assert property (p_prog_base) else $error("write address not page base");
  property p_word_count; flashProgStart |-> wordCnt == (1 << PAGE_W); endproperty
  a_word_count: assert property (p_word_count) else $error("streamed word count wrong");
  property p_word_order; progWordValid && $past(progWordValid) |-> progWordIndex == $past(progWordIndex) + 1'b1;
  endproperty
  a_word_order: assert property (p_word_order) else $error("word index out of order");
  property p_first_word; $rose(progWordValid) |-> progWordIndex == '0; endproperty
  a_first_word: assert property (p_first_word) else $error("stream not starting at word 0");
  property p_one_op; $onehot0({flashEraseStart, flashProgStart, flashReadStart}); endproperty
  a_one_op: assert property (p_one_op) else $error("two flash operations at once");
  property p_hold_op; flashEraseStart || flashProgStart || flashReadStart |-> cpuHold; endproperty
  a_hold_op: assert property (p_hold_op) else $error("core not held during operation");
  property p_read_end; readPend && flashDone |=> !cpuHold; endproperty
  a_read_end: assert property (p_read_end) else $error("hold not released after read");
  property p_erase_end; erasePend && flashDone |=> !cpuHold; endproperty
  a_erase_end: assert property (p_erase_end) else $error("hold not released after erase");
  property p_write_sweep; progPend && flashDone |=> cpuHold [*8] ##[1:100] !cpuHold; endproperty
  a_write_sweep: assert property (p_write_sweep) else $error("buffer sweep after write wrong");
  property p_rd_stable; !sfrRdEn |=> $stable(sfrRdData); endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved without strobe");
endmodule // flic_top_monitor

// *** tb/flic_flash_model.sv ***
// Behavioural flash array answering page and word requests
module flic_flash_model #(
  parameter ADDR_W = 15,
  parameter PAGE_W = 6
) (
  // Clock and reset
  input  wire              clock,
  input  wire              arst_n,
  // Response speed
  input  wire              slow,
  // Requests
  input  wire              eraseStart,
  input  wire              progStart,
  input  wire              readStart,
  input  wire [ADDR_W-1:0] addr,
  input  wire              wordValid,
  input  wire [PAGE_W-1:0] wordIndex,
  input  wire [15:0]       wordData,
  // Answers
  output logic             done,
  output logic [15:0]      readData,
  output int               opsCnt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0]       mem [0:(1<<ADDR_W)-1];
  logic [15:0]       page [0:(1<<PAGE_W)-1];
  logic [2:0]        op;
  logic [ADDR_W-1:0] opAddr;
  int                waitCnt;

  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = {i[7:0], ~i[7:0]};
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      done     <= 1'b0;
      readData <= 16'h0000;
      op       <= 3'h0;
      waitCnt  <= 0;
      opsCnt   <= 0;
    end else begin
      done     <= 1'b0;
      // Data lines toggle while not answering
      readData <= ~readData;
      if (wordValid) begin
        page[wordIndex] <= wordData;
      end
      if (eraseStart || progStart || readStart) begin
        op      <= {eraseStart, progStart, readStart};
        opAddr  <= addr;
        waitCnt <= slow ? 9 : 1;
        opsCnt  <= opsCnt + 1;
      end else if (op != 3'h0 && waitCnt > 0) begin
        waitCnt <= waitCnt - 1;
      end else if (op != 3'h0) begin
        done <= 1'b1;
        op   <= 3'h0;
        for (int i = 0; i < (1 << PAGE_W); i++) begin
          if (op[2]) mem[{opAddr[ADDR_W-1:PAGE_W], i[PAGE_W-1:0]}] <= 16'hFFFF;
          if (op[1]) mem[{opAddr[ADDR_W-1:PAGE_W], i[PAGE_W-1:0]}] <= page[i];
        end
        if (op[0]) readData <= mem[opAddr];
      end
    end
  end
endmodule // flic_flash_model

// *** tb/flic_top_tb.sv ***
// Register-level testbench for the flash programming controller
module flic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam AW = 13;
  localparam PW = 5;

  logic          clock, arst_n, sfrSector, sfrWrEn, sfrRdEn, slow;
  logic [2:0]    sfrIndex;
  logic [7:0]    sfrWrData, sfrRdData;
  logic          cpuHold, flashEraseStart, flashProgStart, flashReadStart;
  logic          progWordValid, flashDone;
  logic [AW-1:0] flashAddr;
  logic [PW-1:0] progWordIndex;
  logic [15:0]   progWordData, flashReadData;
  int            opsCnt, mismatches, checks_done, n;

  flic_top #(.ADDR_W(AW), .PAGE_W(PW), .UNLOCK_CYCLES(20)) i_flic_top (
    .clock(clock), .arst_n(arst_n), .sfrSector(sfrSector), .sfrIndex(sfrIndex), .sfrWrEn(sfrWrEn),
    .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .cpuHold(cpuHold),
    .flashEraseStart(flashEraseStart), .flashProgStart(flashProgStart), .flashReadStart(flashReadStart),
    .flashAddr(flashAddr), .progWordValid(progWordValid), .progWordIndex(progWordIndex),
    .progWordData(progWordData), .flashDone(flashDone), .flashReadData(flashReadData));

  flic_flash_model #(.ADDR_W(AW), .PAGE_W(PW)) i_flic_flash_model (
    .clock(clock), .arst_n(arst_n), .slow(slow), .eraseStart(flashEraseStart), .progStart(flashProgStart),
    .readStart(flashReadStart), .addr(flashAddr), .wordValid(progWordValid), .wordIndex(progWordIndex),
    .wordData(progWordData), .done(flashDone), .readData(flashReadData), .opsCnt(opsCnt));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic wr(input logic sec, input logic [2:0] idx, input logic [7:0] d);
    sfrSector = sec;
    sfrIndex  = idx;
    sfrWrData = d;
    sfrWrEn   = 1'b1;
    @(negedge clock);
    sfrWrEn = 1'b0;
    @(negedge clock);
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic sec, input logic [2:0] idx, input logic [7:0] exp);
    sfrSector = sec;
    sfrIndex  = idx;
    sfrRdEn   = 1'b1;
    @(negedge clock);
    sfrRdEn = 1'b0;
    chk8(sfrRdData, exp);
    @(negedge clock);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (cpuHold !== 1'b0 && k < 500) begin
      @(negedge clock);
      k++;
    end
    if (k >= 500) mismatches++;
  endtask

  task automatic unlock(input logic [15:0] p1);
    wr(1'b1, 3'h0, 8'h68);
    wr(1'b0, 3'h2, p1[7:0]);
    wr(1'b1, 3'h4, p1[15:8]);
    wr(1'b0, 3'h3, 8'h78);
    wr(1'b1, 3'h5, 8'h56);
    wr(1'b0, 3'h4, 8'hBC);
    wr(1'b1, 3'h6, 8'h9A);
    repeat (30) @(negedge clock);
  endtask

  task automatic results;
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    {sfrSector, sfrWrEn, sfrRdEn, slow, sfrIndex, sfrWrData} = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (6) @(negedge clock);
    arst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(1'b0, i[2:0], 8'h00);
      rd(1'b1, i[2:0], 8'h00);
    end
    wr(1'b0, 3'h7, 8'hFF);
    rd(1'b0, 3'h7, 8'h00);
    wr(1'b0, 3'h0, 8'hA5);
    rd(1'b0, 3'h0, 8'hA5);
    wr(1'b1, 3'h2, 8'h01);
    wr(1'b0, 3'h0, 8'h20);
    wr(1'b0, 3'h1, 8'h11);
    wr(1'b1, 3'h3, 8'h22);
    rd(1'b0, 3'h0, 8'h20);
    wr(1'b1, 3'h0, 8'h84);
    wait_idle;
    chk16(16'(opsCnt), 16'h0000);
    rd(1'b1, 3'h0, 8'h00);
    unlock(16'h1111);
    rd(1'b1, 3'h0, 8'h60);
    unlock(16'h1234);
    rd(1'b1, 3'h0, 8'hE0);
    wr(1'b0, 3'h0, 8'h25);
    wr(1'b1, 3'h0, 8'h94);
    wait_idle;
    chk16(i_flic_flash_model.mem[13'h120], 16'hFFFF);
    chk16(i_flic_flash_model.mem[13'h13F], 16'hFFFF);
    chk16(i_flic_flash_model.mem[13'h140], 16'h40BF);
    rd(1'b1, 3'h0, 8'h90);
    wr(1'b1, 3'h1, 8'h01);
    rd(1'b1, 3'h1, 8'h01);
    repeat (40) @(negedge clock);
    rd(1'b1, 3'h1, 8'h00);
    wr(1'b0, 3'h0, 8'h20);
    for (int i = 0; i < 33; i++) begin
      wr(1'b0, 3'h1, i[7:0]);
      wr(1'b1, 3'h3, 8'hA0);
      if (i == 0) rd(1'b0, 3'h0, 8'h21);
    end
    rd(1'b0, 3'h0, 8'h3F);
    rd(1'b1, 3'h2, 8'h01);
    rd(1'b1, 3'h3, 8'hA0);
    slow = 1'b1;
    wr(1'b1, 3'h0, 8'h84);
    wait_idle;
    slow = 1'b0;
    for (int i = 0; i < 31; i++) begin
      chk16(i_flic_flash_model.mem[13'h120 + i], {8'hA0, i[7:0]});
    end
    chk16(i_flic_flash_model.mem[13'h13F], 16'hA020);
    rd(1'b1, 3'h0, 8'h80);
    wr(1'b0, 3'h0, 8'h20);
    wr(1'b1, 3'h0, 8'h84);
    wait_idle;
    chk16(i_flic_flash_model.mem[13'h120], 16'h0000);
    n = opsCnt;
    for (int m = 2; m < 8; m++) begin
      if (m == 3 || m == 6) continue;
      wr(1'b1, 3'h0, {1'b1, m[2:0], 4'h4});
      wait_idle;
      rd(1'b1, 3'h0, {1'b1, m[2:0], 4'h0});
    end
    chk16(16'(opsCnt - n), 16'h0000);
    wr(1'b0, 3'h0, 8'h05);
    wr(1'b1, 3'h2, 8'h00);
    wr(1'b1, 3'h0, 8'h31);
    wait_idle;
    rd(1'b0, 3'h1, 8'h20);
    rd(1'b1, 3'h0, 8'h30);
    wr(1'b1, 3'h0, 8'h33);
    wait_idle;
    rd(1'b0, 3'h1, 8'hFA);
    rd(1'b1, 3'h3, 8'h05);
    rd(1'b1, 3'h0, 8'h32);
    results;
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    results;
  end
endmodule // flic_top_tb

bind flic_top flic_top_monitor #(.ADDR_W(ADDR_W), .PAGE_W(PAGE_W)) i_flic_top_monitor (
  .clock(clock), .arst_n(arst_n), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .cpuHold(cpuHold),
  .flashEraseStart(flashEraseStart), .flashProgStart(flashProgStart), .flashReadStart(flashReadStart),
  .flashAddr(flashAddr), .progWordValid(progWordValid), .progWordIndex(progWordIndex), .flashDone(flashDone));
